// ===== include/dci_pkg.sv
package dci_pkg;

  localparam int DCI_NUM_POS = 20;
  localparam int DCI_PW = 5;

  typedef logic [7:0] dci_byte_t;
  typedef logic [DCI_PW-1:0] dci_pos_t;
  typedef logic [6:0] dci_cycles_t;

  typedef enum logic [1:0] {
    DCI_MODE_NORMAL,
    DCI_MODE_BLANK,
    DCI_MODE_INVERSE
  } dci_mode_t;

  // Control words.
  localparam dci_byte_t DCI_CMD_PREFIX = 8'h01;
  localparam dci_byte_t DCI_CMD_DT16 = 8'h05;
  localparam dci_byte_t DCI_CMD_DT32 = 8'h06;
  localparam dci_byte_t DCI_CMD_DT64 = 8'h07;
  localparam dci_byte_t DCI_CMD_NORMAL = 8'h08;
  localparam dci_byte_t DCI_CMD_BLANK = 8'h09;
  localparam dci_byte_t DCI_CMD_INVERSE = 8'h0A;
  localparam dci_byte_t DCI_CMD_START = 8'h0E;
  localparam dci_byte_t DCI_CMD_DUTY_LO = 8'h40;
  localparam dci_byte_t DCI_CMD_DUTY_DARK = 8'h42;
  localparam dci_byte_t DCI_CMD_DUTY_HI = 8'h7F;
  localparam dci_byte_t DCI_CMD_CNT_LO = 8'h81;
  localparam dci_byte_t DCI_CMD_CNT_HI = 8'h94;
  localparam dci_byte_t DCI_CMD_PTR_LO = 8'hC0;
  localparam dci_byte_t DCI_CMD_PTR_HI = 8'hD3;

  // Digit times and the minimum off time, in cycles per character position.
  localparam dci_cycles_t DCI_DT_16 = 7'h10;
  localparam dci_cycles_t DCI_DT_32 = 7'h20;
  localparam dci_cycles_t DCI_DT_64 = 7'h40;
  localparam dci_cycles_t DCI_OFF_MIN = 7'h03;

  // Reset values.
  localparam dci_byte_t DCI_RST_DUTY = 8'h40;
  localparam dci_pos_t DCI_RST_CNT = 5'h00;
  localparam dci_pos_t DCI_RST_PTR = 5'h00;
  localparam dci_cycles_t DCI_RST_DT = DCI_DT_64;
  localparam dci_mode_t DCI_RST_MODE = DCI_MODE_NORMAL;

  // APB register offsets and field positions.
  localparam logic [11:0] DCI_REG_BYTE = 12'h000;
  localparam logic [11:0] DCI_REG_STATUS = 12'h004;
  localparam logic [11:0] DCI_REG_CONFIG = 12'h008;
  localparam int DCI_STAT_PTR_LSB = 0;
  localparam int DCI_STAT_CNT_LSB = 8;
  localparam int DCI_STAT_RUN_BIT = 16;
  localparam int DCI_STAT_PAR_BIT = 17;
  localparam int DCI_STAT_CTRL_BIT = 18;
  localparam int DCI_CFG_DUTY_LSB = 0;
  localparam int DCI_CFG_DT_LSB = 8;
  localparam int DCI_CFG_MODE_LSB = 16;

  // On cycles of a slot: none up to the dark codes, then code minus 0x42,
  // capped so that the minimum off time always remains.
  function automatic dci_cycles_t dci_on_count(input dci_byte_t duty, input dci_cycles_t dt);
    dci_byte_t raw;
    dci_byte_t cap;
    raw = duty - DCI_CMD_DUTY_DARK;
    cap = {1'b0, dt - DCI_OFF_MIN};
    if (duty <= DCI_CMD_DUTY_DARK) begin
      return 7'h00;
    end
    return (raw > cap) ? cap[6:0] : raw[6:0];
  endfunction

endpackage

// ===== src/dci_buf_mem.sv
`timescale 1ns/100ps
module dci_buf_mem #(
  parameter int DEPTH = 20,
  parameter int WIDTH = 8,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // The array itself has no reset; only its read register does.
  always_ff @(posedge clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
  end

endmodule

// ===== src/dci_refresh.sv
`timescale 1ns/100ps
module dci_refresh
  import dci_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Settings
  input wire logic run,
  input wire dci_pkg::dci_pos_t digit_count,
  input wire dci_pkg::dci_cycles_t digit_time,
  input wire dci_pkg::dci_cycles_t on_count,
  // Scan state
  output dci_pkg::dci_pos_t pos_q,
  output logic on_q
);
  import dci_pkg::*;

  dci_cycles_t slot_q;
  dci_cycles_t slot_d;
  dci_pos_t pos_d;
  wire active = run && (digit_count != '0);
  wire slot_end = (slot_q >= digit_time - 7'h01);
  wire pos_last = ({1'b0, pos_q} + 6'h01 >= {1'b0, digit_count});

  // A slot ends early when a shorter digit time is chosen mid-slot.
  assign slot_d = (!active || slot_end) ? 7'h00 : slot_q + 7'h01;
  // A count lowered mid-slot to or below the current position sends the scan back to the first position at once.
  assign pos_d = !active ? '0 : (pos_q >= digit_count) ? '0 :
                 !slot_end ? pos_q : pos_last ? '0 : pos_q + 5'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= '0;
      pos_q <= '0;
      on_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      pos_q <= pos_d;
      on_q <= active && (slot_d < on_count);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  scan_range_a: assert property (active && $past(active) && $stable(digit_count) |-> pos_q < digit_count)
    else $error("Scan position beyond digit count.");
  on_bound_a: assert property (on_q |-> slot_q < $past(on_count) && slot_q <= $past(digit_time) - 7'h03)
    else $error("Position driven outside its on cycles.");

endmodule

// ===== src/dci_top.sv
`timescale 1ns/100ps
module dci_top
  import dci_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host byte port pins
  input wire logic byte_load_strobe,
  input wire logic [7:0] data_pins,
  // Tube drive
  output logic tube_enable,
  output dci_pkg::dci_pos_t grid_index,
  output logic grid_on,
  output logic [6:0] char_code,
  output logic char_inverse,
  output logic port_parallel
);
  import dci_pkg::*;

  typedef enum logic {DCI_ST_DATA, DCI_ST_CTRL} dci_state_t;

  dci_state_t state_q;
  dci_state_t state_d;
  logic strobe_s1_q;
  logic strobe_s2_q;
  logic strobe_s3_q;
  dci_byte_t data_s1_q;
  dci_byte_t data_s2_q;
  dci_byte_t data_s3_q;
  logic [1:0] warm_q;
  wire sync_warm = &warm_q;
  dci_pos_t ptr_q;
  dci_pos_t ptr_d;
  dci_pos_t cnt_q;
  dci_pos_t cnt_d;
  dci_byte_t duty_q;
  dci_byte_t duty_d;
  dci_cycles_t dt_q;
  dci_cycles_t dt_d;
  dci_mode_t mode_q;
  dci_mode_t mode_d;
  logic run_q;
  logic par_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  dci_pos_t scan_pos;
  logic scan_on;
  dci_pos_t pos_d1_q;
  logic on_d1_q;
  dci_byte_t rd_byte;
  dci_pos_t grid_q;
  logic grid_on_q;
  logic [6:0] char_q;
  logic char_inv_q;
  dci_cycles_t on_cnt;

  // Pin inputs pass two flip-flops; the third stage only serves edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      data_s3_q <= '0;
      warm_q <= 2'h0;
    end else begin
      strobe_s1_q <= byte_load_strobe;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
      data_s1_q <= data_pins;
      data_s2_q <= data_s1_q;
      data_s3_q <= data_s2_q;
      warm_q <= warm_q + {1'b0, !sync_warm};
    end
  end

  // Nothing is compared until all three stages hold pin samples, so a level
  // already standing on the pins at reset release is not taken for an edge.
  wire pin_load = sync_warm && strobe_s2_q && !strobe_s3_q;

  // APB decode. A byte written over the bus waits one cycle when a pin load
  // lands in the same cycle, so neither byte is lost.
  wire apb_access = psel && penable && !pready_q;
  wire sel_byte = (paddr == DCI_REG_BYTE);
  wire sel_status = (paddr == DCI_REG_STATUS);
  wire sel_config = (paddr == DCI_REG_CONFIG);
  wire apb_blocked = pwrite && sel_byte && pin_load;
  wire apb_done = apb_access && !apb_blocked;
  wire apb_byte_wr = apb_done && pwrite && sel_byte;
  wire apb_bad = !(sel_byte || sel_status || sel_config);

  wire load = pin_load || apb_byte_wr;
  wire dci_byte_t in_byte = pin_load ? data_s2_q : pwdata[7:0];
  wire is_prefix = (in_byte == DCI_CMD_PREFIX);
  wire in_ctrl = (state_q == DCI_ST_CTRL);

  // Command decode. Control words act whether or not refresh has started.
  wire char_wr = load && (in_ctrl ? is_prefix : !is_prefix);
  wire cmd = load && in_ctrl && !is_prefix;
  wire cmd_dt16 = cmd && (in_byte == DCI_CMD_DT16);
  wire cmd_dt32 = cmd && (in_byte == DCI_CMD_DT32);
  wire cmd_dt64 = cmd && (in_byte == DCI_CMD_DT64);
  wire cmd_norm = cmd && (in_byte == DCI_CMD_NORMAL);
  wire cmd_blank = cmd && (in_byte == DCI_CMD_BLANK);
  wire cmd_inv = cmd && (in_byte == DCI_CMD_INVERSE);
  wire cmd_start = cmd && (in_byte == DCI_CMD_START);
  wire cmd_duty = cmd && (in_byte >= DCI_CMD_DUTY_LO) && (in_byte <= DCI_CMD_DUTY_HI);
  wire cmd_cnt = cmd && (in_byte >= DCI_CMD_CNT_LO) && (in_byte <= DCI_CMD_CNT_HI);
  wire cmd_ptr = cmd && (in_byte >= DCI_CMD_PTR_LO) && (in_byte <= DCI_CMD_PTR_HI);
  wire cmd_known = cmd_dt16 || cmd_dt32 || cmd_dt64 || cmd_norm || cmd_blank || cmd_inv ||
                   cmd_start || cmd_duty || cmd_cnt || cmd_ptr;

  wire dci_byte_t ptr_off = in_byte - DCI_CMD_PTR_LO;
  wire dci_byte_t cnt_off = in_byte - DCI_CMD_CNT_LO;
  wire dci_pos_t ptr_inc = ptr_q + 5'h01;
  // The last buffer position also wraps, so a zero count never runs off the end.
  wire ptr_wrap = (ptr_inc == cnt_q) || (int'(ptr_inc) >= DCI_NUM_POS);

  assign state_d = !load ? state_q : (!in_ctrl && is_prefix) ? DCI_ST_CTRL : DCI_ST_DATA;
  assign ptr_d = cmd_ptr ? ptr_off[4:0] : char_wr ? (ptr_wrap ? '0 : ptr_inc) : ptr_q;
  assign cnt_d = cmd_cnt ? cnt_off[4:0] + 5'h01 : cnt_q;
  assign duty_d = cmd_duty ? in_byte : duty_q;
  assign dt_d = cmd_dt16 ? DCI_DT_16 : cmd_dt32 ? DCI_DT_32 : cmd_dt64 ? DCI_DT_64 : dt_q;
  assign mode_d = cmd_norm ? DCI_MODE_NORMAL : cmd_blank ? DCI_MODE_BLANK :
                  cmd_inv ? DCI_MODE_INVERSE : mode_q;
  assign on_cnt = dci_on_count(duty_q, dt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DCI_ST_DATA;
      ptr_q <= DCI_RST_PTR;
      cnt_q <= DCI_RST_CNT;
      duty_q <= DCI_RST_DUTY;
      dt_q <= DCI_RST_DT;
      mode_q <= DCI_RST_MODE;
      run_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      duty_q <= duty_d;
      dt_q <= dt_d;
      mode_q <= mode_d;
      run_q <= run_q || cmd_start;
      par_q <= par_q || (sync_warm && (data_s2_q[7:2] != data_s3_q[7:2]));
    end
  end

  dci_buf_mem #(
    .DEPTH(DCI_NUM_POS),
    .WIDTH(8),
    .AW(DCI_PW)
  ) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(char_wr),
    .waddr(ptr_q),
    .wdata(in_byte),
    .raddr(scan_pos),
    .rdata_q(rd_byte)
  );

  dci_refresh u_refresh (
    .clk(pclk),
    .rst_n(presetn),
    .run(run_q),
    .digit_count(cnt_q),
    .digit_time(dt_q),
    .on_count(on_cnt),
    .pos_q(scan_pos),
    .on_q(scan_on)
  );

  // The position is delayed one cycle to line up with the registered read.
  wire flagged = rd_byte[7];
  wire hide = (mode_q == DCI_MODE_BLANK) && flagged;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_d1_q <= '0;
      on_d1_q <= 1'b0;
      grid_q <= '0;
      grid_on_q <= 1'b0;
      char_q <= '0;
      char_inv_q <= 1'b0;
    end else begin
      pos_d1_q <= scan_pos;
      on_d1_q <= scan_on;
      grid_q <= pos_d1_q;
      grid_on_q <= run_q && on_d1_q && !hide;
      char_q <= rd_byte[6:0];
      char_inv_q <= (mode_q == DCI_MODE_INVERSE) && flagged && on_d1_q;
    end
  end

  // Status and configuration are read-only; writes to them are dropped without an error.
  wire [31:0] status_word = ({27'h0, ptr_q} << DCI_STAT_PTR_LSB) | ({27'h0, cnt_q} << DCI_STAT_CNT_LSB) |
                            ({31'h0, run_q} << DCI_STAT_RUN_BIT) | ({31'h0, par_q} << DCI_STAT_PAR_BIT) |
                            ({31'h0, in_ctrl} << DCI_STAT_CTRL_BIT);
  wire [31:0] config_word = ({24'h0, duty_q} << DCI_CFG_DUTY_LSB) | ({25'h0, dt_q} << DCI_CFG_DT_LSB) |
                            ({30'h0, mode_q} << DCI_CFG_MODE_LSB);
  wire [31:0] read_word = sel_status ? status_word : sel_config ? config_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apb_done;
      pslverr_q <= apb_done && apb_bad;
      prdata_q <= (apb_done && !pwrite) ? read_word : prdata_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tube_enable = run_q;
  assign grid_index = grid_q;
  assign grid_on = grid_on_q;
  assign char_code = char_q;
  assign char_inverse = char_inv_q;
  assign port_parallel = par_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ptr_advance_a: assert property (char_wr && !ptr_wrap |=> ptr_q == $past(ptr_q) + 5'h01)
    else $error("Pointer did not advance after a character.");
  ptr_wrap_a: assert property (char_wr && (cnt_q == ptr_q + 5'h01) |=> ptr_q == 5'h00)
    else $error("Pointer did not wrap at the digit count.");
  wrap_end_a: assert property (char_wr && (int'(ptr_q) == DCI_NUM_POS - 1) |=> ptr_q == 5'h00)
    else $error("Pointer ran past the last position.");
  ptr_load_a: assert property (cmd_ptr |=> ptr_q == $past(in_byte[4:0]))
    else $error("Pointer load took the wrong position.");
  dt16_select_a: assert property (cmd_dt16 |=> dt_q == 7'h10)
    else $error("Digit time 16 not selected.");
  dt64_select_a: assert property (cmd_dt64 |=> dt_q == 7'h40)
    else $error("Digit time 64 not selected.");
  duty_load_a: assert property (cmd_duty |=> duty_q == $past(in_byte))
    else $error("Duty code not stored.");
  blank_mode_a: assert property (cmd_blank |=> mode_q == DCI_MODE_BLANK)
    else $error("Blank mode not selected.");
  blank_hide_a: assert property (hide && run_q |=> !grid_on_q)
    else $error("Flagged character shown in blank mode.");
  inv_lit_a: assert property (char_inv_q |-> grid_on_q)
    else $error("Inverse flag raised on a dark position.");
  start_run_a: assert property (cmd_start |=> tube_enable)
    else $error("Refresh did not start on its command.");
  dt_select_a: assert property (cmd_dt32 |=> dt_q == 7'h20 ##1 (dt_q == 7'h20 || $past(cmd)))
    else $error("Digit time 32 not selected.");
  dark_duty_a: assert property (grid_on_q |-> $past(on_cnt, 3) != 7'h00)
    else $error("Position lit with a dark duty code.");
  hold_dark_a: assert property (!tube_enable |-> !grid_on_q && !char_inv_q)
    else $error("Tube driven during hold.");
  run_sticky_a: assert property (tube_enable |=> tube_enable)
    else $error("Refresh stopped without reset.");
  escape_store_a: assert property (load && in_ctrl && is_prefix |-> char_wr && !cmd ##1 !in_ctrl)
    else $error("Escaped 01 not stored as a character.");
  prefix_enter_a: assert property (load && !in_ctrl && is_prefix |=> in_ctrl && $stable(ptr_q))
    else $error("Prefix byte not taken as prefix.");
  unknown_cmd_a: assert property (cmd && !cmd_known |=>
                                  $stable(ptr_q) && $stable(cnt_q) && $stable(duty_q) && $stable(dt_q) &&
                                  $stable(mode_q) && $stable(run_q))
    else $error("Unknown control word changed a setting.");
  count_load_a: assert property (cmd_cnt |=> cnt_q == $past(in_byte[4:0]) && cnt_q != 5'h00)
    else $error("Digit count load wrong.");

endmodule

// ===== dv/dci_host_model.sv
`timescale 1ns/100ps
module dci_host_model (
  // Clock
  input wire logic pclk,
  // Byte port pins
  output logic byte_load_strobe,
  output logic [7:0] data_pins
);
  initial begin
    byte_load_strobe = 1'b0;
    data_pins = 8'h00;
  end

  // Data leads the strobe by a cycle and stays well past the three-cycle capture.
  // Released pins show the inverse byte, so a stale value can never look right.
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    data_pins <= b;
    @(posedge pclk);
    byte_load_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    byte_load_strobe <= 1'b0;
    data_pins <= ~b;
    repeat (3) @(posedge pclk);
  endtask

  task automatic cmd(input logic [7:0] w);
    send(8'h01);
    send(w);
  endtask
endmodule

// ===== dv/display_command_interpreter_bench.sv
`timescale 1ns/100ps
module display_command_interpreter_bench;
  import dci_pkg::*;
  localparam logic [7:0] DT_C [5] = '{8'h05, 8'h05, 8'h06, 8'h07, 8'h06};
  localparam logic [7:0] DU_C [5] = '{8'h44, 8'h7F, 8'h52, 8'h7F, 8'h60};
  localparam int ON_C [5] = '{2, 13, 16, 61, 29};
  logic pclk = 1'b0;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd, st;
  logic pready, pslverr, er, tube_enable, grid_on, char_inverse, port_parallel;
  logic byte_load_strobe;
  logic [7:0] data_pins;
  logic [6:0] char_code;
  dci_pos_t grid_index;
  int fails = 0;
  int check_count = 0;

  always #5 pclk = ~pclk;

  dci_top i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .byte_load_strobe(byte_load_strobe),
    .data_pins(data_pins), .tube_enable(tube_enable), .grid_index(grid_index),
    .grid_on(grid_on), .char_code(char_code), .char_inverse(char_inverse),
    .port_parallel(port_parallel)
  );

  dci_host_model i_host (.pclk(pclk), .byte_load_strobe(byte_load_strobe), .data_pins(data_pins));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1);
  endtask

  task automatic t_reset();
    apb(0, DCI_REG_STATUS, 0);
    chk(rd, 32'h00000000);
    apb(0, DCI_REG_CONFIG, 0);
    chk(rd, 32'h00004040);
    chk(tube_enable, 0);
  endtask

  task automatic t_cmds();
    for (int i = 0; i < 3; i++) begin
      i_host.cmd(8'h05 + 8'(i));
      apb(0, DCI_REG_CONFIG, 0);
      chk(rd[14:8], 7'h10 << i);
      i_host.cmd(8'h08 + 8'(i));
      apb(0, DCI_REG_CONFIG, 0);
      chk(rd[17:16], i);
    end
    i_host.cmd(8'h7F);
    apb(0, DCI_REG_CONFIG, 0);
    chk(rd[7:0], 8'h7F);
    i_host.cmd(8'h81);
    apb(0, DCI_REG_STATUS, 0);
    chk(rd[12:8], 1);
    i_host.cmd(8'h94);
    for (int i = 0; i < 20; i++) begin
      i_host.cmd(8'hC0 + 8'(i));
      apb(0, DCI_REG_STATUS, 0);
      chk(rd[4:0], i);
    end
    chk(rd[12:8], 20);
    i_host.send(8'h01);
    apb(0, DCI_REG_STATUS, 0);
    chk(rd[18], 1);
    i_host.send(8'h01);
    apb(0, DCI_REG_STATUS, 0);
    chk(rd[18:0], {3'b010, 8'h14, 8'h00});
    for (int i = 0; i < 2; i++) begin
      apb(0, DCI_REG_CONFIG, 0);
      st = rd;
      i_host.cmd(i == 0 ? 8'h02 : 8'hFF);
      apb(0, DCI_REG_CONFIG, 0);
      chk(rd, st);
      apb(0, DCI_REG_STATUS, 0);
      chk(rd[18:0], {3'b010, 8'h14, 8'h00});
    end
  endtask

  task automatic t_stream();
    i_host.cmd(8'hC0);
    for (int i = 0; i < 23; i++) begin
      if (i == 20) begin
        i_host.cmd(8'h83);
        i_host.cmd(8'hC0);
      end
      i_host.send(8'h41 + 8'(i));
      apb(0, DCI_REG_STATUS, 0);
      chk(rd[4:0], i < 20 ? (i + 1) % 20 : (i - 19) % 3);
    end
    apb(1, DCI_REG_BYTE, 32'h0000005A);
    apb(1, DCI_REG_STATUS, 32'hFFFFFFFF);
    apb(0, DCI_REG_STATUS, 0);
    chk(rd[4:0], 1);
    apb(0, 12'h00C, 0);
    chk(er, 1);
    chk(rd, 0);
    // A bus byte accepted in the cycle of a pin load must wait, not be lost.
    fork
      i_host.send(8'h30);
      begin
        repeat (2) @(posedge pclk);
        apb(1, DCI_REG_BYTE, 32'h00000031);
      end
    join
    apb(0, DCI_REG_STATUS, 0);
    chk(rd[4:0], 0);
  endtask

  // On-run length of the next lit slot; the caller discards one run after a change.
  task automatic on_len(output int len);
    int n;
    n = 0;
    len = 0;
    while (grid_on !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    while (grid_on === 1'b1 && len < 300) begin
      @(posedge pclk);
      len++;
    end
  endtask

  task automatic t_refresh();
    int len, bad, hit;
    bad = 0;
    i_host.cmd(8'h81);
    i_host.cmd(8'hC0);
    i_host.send(8'hC1);
    i_host.cmd(8'h0A);
    i_host.cmd(8'h44);
    repeat (200) @(posedge pclk) bad += (grid_on !== 1'b0 || tube_enable !== 1'b0);
    chk(bad, 0);
    i_host.cmd(8'h0E);
    chk(tube_enable, 1);
    for (int i = 0; i < 5; i++) begin
      i_host.cmd(DT_C[i]);
      i_host.cmd(DU_C[i]);
      on_len(len);
      on_len(len);
      chk(len, ON_C[i]);
    end
    for (int k = 0; k < 300 && grid_on !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
    chk({char_inverse, char_code}, 8'hC1);
    i_host.cmd(8'h42);
    repeat (200) @(posedge pclk) bad += (grid_on !== 1'b0 || tube_enable !== 1'b1);
    chk(bad, 0);
    i_host.cmd(8'h83);
    i_host.cmd(8'h7F);
    hit = 0;
    repeat (400) @(posedge pclk) begin
      bad += (grid_index > 5'h02);
      hit += (grid_index == 5'h02 && grid_on === 1'b1);
    end
    chk(bad, 0);
    chk(hit > 0, 1);
    i_host.cmd(8'h81);
    i_host.cmd(8'h09);
    repeat (200) @(posedge pclk) bad += (grid_on !== 1'b0);
    chk(bad, 0);
    i_host.cmd(8'h08);
    for (int k = 0; k < 300 && grid_on !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
    chk({char_inverse, char_code}, 8'h41);
  endtask

  // Reset in mid-run, with the pins left showing a released byte.
  task automatic t_rerun();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({tube_enable, grid_on, char_inverse, port_parallel}, 0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, DCI_REG_STATUS, 0);
    chk(rd, 32'h00000000);
    apb(0, DCI_REG_CONFIG, 0);
    chk(rd, 32'h00004040);
    i_host.send(8'h20);
    chk(port_parallel, 1);
    apb(0, DCI_REG_STATUS, 0);
    chk(rd[4:0], 1);
  endtask

  initial begin
    presetn <= 1'b0;
    paddr <= 12'h000;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h00000000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_cmds();
    t_stream();
    t_refresh();
    t_rerun();
    end_sim();
  end

  // The run needs some three thousand cycles; this leaves ample margin.
  initial begin
    #600000;
    fails++;
    end_sim();
  end
endmodule
